// ==== hdl/afp_sequencer.sv ====
// fault supervision and restart sequencer of the amplifier
`timescale 1ns/1ps
`default_nettype none
`include "afp_params.svh"
module afp_sequencer #(
   parameter int CYC_PER_MS = `AFP_CYC_PER_MS,
   parameter int TAU_MS     = `AFP_LIMIT_TAU_MS
) (
   // clock and reset
   input  wire logic       clock,
   input  wire logic       reset,
   // host mode input, three levels as two comparator bits
   input  wire logic [1:0] mode_level,
   // analog comparator flags
   input  wire logic       temp_fold_flag,
   input  wire logic       temp_mute_flag,
   input  wire logic       temp_shutdown_flag,
   input  wire logic       current_limit_flag,
   input  wire logic       output_window_flag,
   input  wire logic       low_supply_flag,
   input  wire logic       high_supply_flag,
   input  wire logic       rail_imbalance_flag,
   // power stage control
   output logic            stage_enable,
   output logic            idle_switching,
   output logic            audio_enable,
   output logic            current_regulate,
   output logic [7:0]      thermal_gain_rollback,
   // diagnostic
   output logic            fault_indicator_n
);
   ////////////////////////////////////////////////////////////////////////
   localparam int MS_CNT_W = $clog2(`AFP_RUN_MS * CYC_PER_MS + 2);
   localparam logic [MS_CNT_W-1:0] IND_REL_CYC =
      MS_CNT_W'(`AFP_IND_REL_MS * CYC_PER_MS);
   localparam logic [MS_CNT_W-1:0] MUTE_CYC    = MS_CNT_W'(`AFP_MUTE_MS * CYC_PER_MS);
   localparam logic [MS_CNT_W-1:0] RUN_CYC     = MS_CNT_W'(`AFP_RUN_MS * CYC_PER_MS);
   localparam logic [MS_CNT_W-1:0] RESTART_CYC = MS_CNT_W'(`AFP_RESTART_MS * CYC_PER_MS);
   localparam logic [MS_CNT_W-1:0] TAU_CYC     = MS_CNT_W'(TAU_MS * CYC_PER_MS);
   localparam logic [MS_CNT_W-1:0] STEP_CYC    = MS_CNT_W'(`AFP_GAIN_STEP_MS * CYC_PER_MS);
   // refuse timings the counters cannot hold
   if (CYC_PER_MS < 1 || TAU_MS < 1 || TAU_MS > `AFP_RUN_MS)
   begin : g_bad_timing
      $error("afp_sequencer timing parameters out of range");
   end
   ////////////////////////////////////////////////////////////////////////
   // synchronised inputs
   logic [9:0] raw_in;
   logic [9:0] syn;
   assign raw_in = {mode_level, temp_fold_flag, temp_mute_flag, temp_shutdown_flag,
                    current_limit_flag, output_window_flag, low_supply_flag,
                    high_supply_flag, rail_imbalance_flag};
   afp_sync #(.WIDTH(10)) u_sync (
      .clock    (clock),
      .reset    (reset),
      .async_in (raw_in),
      .sync_out (syn)
   );
   wire [1:0] mode_s   = syn[9:8];
   wire       fold_s   = syn[7];
   wire       tmute_s  = syn[6];
   wire       otp_s    = syn[5];
   wire       climit_s = syn[4];
   wire       window_s = syn[3];
   wire       uv_s     = syn[2];
   wire       ov_s     = syn[1];
   wire       ub_s     = syn[0]; // comparator decides 0.15 of span
   wire       want_run  = (mode_s == afp_pkg::AFP_MODE_OPER);
   wire       standby_s = (mode_s == afp_pkg::AFP_MODE_STANDBY) || (mode_s == 2'b11);
   // states in which the power stage switches
   function automatic logic stage_state(input afp_pkg::afp_state_t s);
      return (s == afp_pkg::AFP_ST_MUTE) || (s == afp_pkg::AFP_ST_OPER);
   endfunction
   ////////////////////////////////////////////////////////////////////////
   afp_pkg::afp_state_t st_q, st_d;
   logic [MS_CNT_W-1:0] tmr_q, tmr_d;      // state timer
   logic [MS_CNT_W-1:0] lim_q;             // current limit duration
   logic [MS_CNT_W-1:0] step_q;            // foldback step timer
   logic [7:0]          gain_q;
   wire tmr_max  = (tmr_q == RUN_CYC);
   wire lim_trip = (lim_q >= TAU_CYC);
   wire stage_on = stage_state(st_q);
   wire sup_trip = uv_s || ub_s;
   always_comb
   begin
      st_d  = st_q;
      tmr_d = tmr_max ? tmr_q : tmr_q + MS_CNT_W'(1);
      case (st_q)
         afp_pkg::AFP_ST_STANDBY:
            if (!standby_s && !sup_trip && !ov_s && !otp_s)
            begin
               st_d  = afp_pkg::AFP_ST_CHECK;
               tmr_d = '0;
            end
         afp_pkg::AFP_ST_CHECK:
         begin
            // timer frozen so a long wait does not shorten the later mute
            tmr_d = tmr_q;
            if (standby_s)
               st_d = afp_pkg::AFP_ST_STANDBY;
            else if (!window_s && !otp_s && !ov_s)
            begin
               st_d  = afp_pkg::AFP_ST_MUTE;
               tmr_d = '0;
            end
         end
         afp_pkg::AFP_ST_MUTE, afp_pkg::AFP_ST_OPER:
         begin
            if (standby_s)
               st_d = afp_pkg::AFP_ST_STANDBY;
            else if (sup_trip)
            begin
               st_d  = afp_pkg::AFP_ST_SUPOFF;
               tmr_d = '0;
            end
            else if (otp_s || ov_s)
               st_d = afp_pkg::AFP_ST_HOLD;
            else if (lim_trip)
            begin
               st_d  = afp_pkg::AFP_ST_OCOFF;
               tmr_d = '0;
            end
            else if (st_q == afp_pkg::AFP_ST_MUTE && want_run && tmr_q >= RUN_CYC)
               st_d = afp_pkg::AFP_ST_OPER;
            else if (st_q == afp_pkg::AFP_ST_OPER && !want_run)
               st_d = afp_pkg::AFP_ST_MUTE;
         end
         afp_pkg::AFP_ST_OCOFF:
            if (tmr_q >= MUTE_CYC)
            begin
               st_d  = afp_pkg::AFP_ST_CHECK;
               tmr_d = MUTE_CYC;
            end
         afp_pkg::AFP_ST_SUPOFF:
            if (sup_trip)
               tmr_d = '0;
            else if (tmr_q >= RESTART_CYC)
            begin
               st_d  = afp_pkg::AFP_ST_STANDBY;
               tmr_d = '0;
            end
         afp_pkg::AFP_ST_HOLD:
            if (!otp_s && !ov_s)
            begin
               st_d  = afp_pkg::AFP_ST_MUTE;
               tmr_d = RUN_CYC;
            end
         default:
            st_d = afp_pkg::AFP_ST_STANDBY;
      endcase
   end
   // after a current shutdown the check and mute resume from 100 ms, so
   // the move to operating falls at 150 ms and the cycle repeats every 100 ms
   wire [MS_CNT_W-1:0] mute_entry = (st_q == afp_pkg::AFP_ST_CHECK) ? tmr_q : '0;
   ////////////////////////////////////////////////////////////////////////
   // diagnostic: low in limit, low until 50 ms after current shutdown, low
   // through every supply-short check, so the host sees a steady low
   wire  ind_low_d = (stage_on && climit_s)
                  || (st_q == afp_pkg::AFP_ST_OCOFF && tmr_q < IND_REL_CYC)
                  || (st_q == afp_pkg::AFP_ST_CHECK && window_s);
   wire  gain_dn = fold_s && (step_q >= STEP_CYC) && (gain_q != 8'h00);
   wire  gain_up = !fold_s && (step_q >= STEP_CYC) && (gain_q != `AFP_GAIN_MAX);
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         st_q       <= afp_pkg::AFP_ST_STANDBY;
         tmr_q      <= '0;
         lim_q      <= '0;
         step_q     <= '0;
         gain_q     <= `AFP_GAIN_MAX;
      end
      else
      begin
         st_q       <= st_d;
         tmr_q      <= (st_d == afp_pkg::AFP_ST_MUTE && st_q == afp_pkg::AFP_ST_CHECK)
                       ? mute_entry : tmr_d;
         lim_q      <= (stage_on && climit_s) ? (lim_trip ? lim_q : lim_q + MS_CNT_W'(1))
                       : '0;
         step_q     <= (step_q >= STEP_CYC) ? '0 : step_q + MS_CNT_W'(1);
         gain_q     <= gain_dn ? gain_q - 8'h01 : (gain_up ? gain_q + 8'h01 : gain_q);
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // registered outputs
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         stage_enable          <= 1'b0;
         idle_switching        <= 1'b0;
         audio_enable          <= 1'b0;
         current_regulate      <= 1'b0;
         thermal_gain_rollback <= `AFP_GAIN_MAX;
         fault_indicator_n     <= 1'b1;
      end
      else
      begin
         stage_enable          <= stage_state(st_d);
         idle_switching        <= (st_d == afp_pkg::AFP_ST_MUTE);
         audio_enable          <= (st_d == afp_pkg::AFP_ST_OPER) && !tmute_s;
         current_regulate      <= stage_on && climit_s;
         thermal_gain_rollback <= tmute_s ? 8'h00 : gain_q;
         fault_indicator_n     <= !ind_low_d;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   a_otp_cut: assert property (@(posedge clock) disable iff (reset)
      otp_s |=> !stage_enable) else $error("stage on during overtemperature");
   a_limit_ind: assert property (@(posedge clock) disable iff (reset)
      (stage_on && climit_s) |=> !fault_indicator_n)
      else $error("indicator high in limit");
   a_window_ind: assert property (@(posedge clock) disable iff (reset)
      (st_q == afp_pkg::AFP_ST_CHECK && window_s) |=> !fault_indicator_n)
      else $error("indicator high on supply short");
   a_limit_stops: assert property (@(posedge clock) disable iff (reset)
      (stage_on && lim_trip && !standby_s) |=> (st_q != afp_pkg::AFP_ST_OPER))
      else $error("no shutdown after limit");
   a_check_first: assert property (@(posedge clock) disable iff (reset)
      $rose(stage_enable) |-> $past(st_q) == afp_pkg::AFP_ST_CHECK ||
      $past(st_q) == afp_pkg::AFP_ST_HOLD) else $error("stage on without check");
   a_window_hold: assert property (@(posedge clock) disable iff (reset)
      (st_q == afp_pkg::AFP_ST_CHECK && window_s) |=> !stage_on) else $error("started on short");
   a_uv_off: assert property (@(posedge clock) disable iff (reset)
      (stage_on && uv_s) |=> st_q == afp_pkg::AFP_ST_SUPOFF) else $error("no undervoltage off");
   a_sup_wait: assert property (@(posedge clock) disable iff (reset)
      (st_q == afp_pkg::AFP_ST_SUPOFF && tmr_q < RESTART_CYC) |=> !stage_on)
      else $error("early supply restart");
   a_ov_resume: assert property (@(posedge clock) disable iff (reset)
      (st_q == afp_pkg::AFP_ST_HOLD && !otp_s && !ov_s) |=> st_q == afp_pkg::AFP_ST_MUTE)
      else $error("no direct overvoltage resume");
   a_mute_idle: assert property (@(posedge clock) disable iff (reset)
      idle_switching |-> stage_enable && !audio_enable) else $error("mute not idle");
   a_oc_ind: assert property (@(posedge clock) disable iff (reset)
      $rose(st_q == afp_pkg::AFP_ST_OCOFF) |=> !fault_indicator_n)
      else $error("indicator high at trip");
   c_oper: cover property (@(posedge clock) st_q == afp_pkg::AFP_ST_OPER);
   c_ocoff: cover property (@(posedge clock) st_q == afp_pkg::AFP_ST_OCOFF);
   c_supoff: cover property (@(posedge clock) st_q == afp_pkg::AFP_ST_SUPOFF);
   c_hold: cover property (@(posedge clock) st_q == afp_pkg::AFP_ST_HOLD);
endmodule
`default_nettype wire

// ==== pkg/afp_params.svh ====
// constants and timing counts of the amplifier fault sequencer
`ifndef AFP_PARAMS_SVH
`define AFP_PARAMS_SVH
`define AFP_CLK_HZ         25000000
`define AFP_CYC_PER_MS     (`AFP_CLK_HZ / 1000)
`define AFP_IND_REL_MS     50
`define AFP_MUTE_MS        100
`define AFP_RUN_MS         150
`define AFP_RESTART_MS     100
`define AFP_LIMIT_TAU_MS   1
`define AFP_GAIN_STEP_MS   1
`define AFP_GAIN_MAX       8'hFF
`endif

// ==== pkg/afp_pkg.sv ====
// types of the amplifier fault sequencer
package afp_pkg;
   typedef enum logic [1:0]
   {
      AFP_MODE_STANDBY = 2'b00,
      AFP_MODE_MUTE    = 2'b01,
      AFP_MODE_OPER    = 2'b10
   } afp_mode_t;
   typedef enum logic [2:0]
   {
      AFP_ST_STANDBY = 3'b000,
      AFP_ST_CHECK   = 3'b001,
      AFP_ST_MUTE    = 3'b010,
      AFP_ST_OPER    = 3'b011,
      AFP_ST_OCOFF   = 3'b100,
      AFP_ST_SUPOFF  = 3'b101,
      AFP_ST_HOLD    = 3'b110
   } afp_state_t;
endpackage

// ==== hdl/afp_sync.sv ====
// two-flop synchroniser bank for the fault flags and mode pins
`timescale 1ns/1ps
`default_nettype none
module afp_sync #(
   parameter int WIDTH = 8
) (
   // clock and reset
   input  wire logic             clock,
   input  wire logic             reset,
   // flags
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;
   if (WIDTH < 1)
   begin : g_bad_width
      $error("afp_sync width must be positive");
   end
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         meta_q   <= '0;
         sync_out <= '0;
      end
      else
      begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule
`default_nettype wire

// ==== verification/afp_host_model.sv ====
// host model: drives the mode pin and reads the diagnostic output
`timescale 1ns/1ps
`default_nettype none
module afp_host_model (
   // clock and reset
   input  wire logic        clock,
   input  wire logic        reset,
   // mode wanted by the bench
   input  wire logic [1:0]  mode_req,
   // device pins
   output logic      [1:0]  mode_level,
   input  wire logic        fault_indicator_n,
   // diagnostic readout
   output logic      [7:0]  fall_count,
   output logic      [15:0] low_run
);
   logic ind_prev;
   ////////////////////////////////////////////////////////////////////////////////
   // moves off the device's sampling edge
   always @(negedge clock)
      mode_level <= mode_req;
   // steady low reads as supply short, repeated falls as load short
   always @(posedge clock)
   begin
      ind_prev <= fault_indicator_n;
      if (reset)
      begin
         fall_count <= 8'h00;
         low_run    <= 16'h0000;
      end
      else
      begin
         if (ind_prev && !fault_indicator_n)
            fall_count <= fall_count + 8'h01;
         low_run <= fault_indicator_n ? 16'h0000 : low_run + 16'h0001;
      end
   end
endmodule
`default_nettype wire

// ==== verification/afp_sequencer_tb.sv ====
// self-checking bench of the amplifier fault sequencer
`timescale 1ns/1ps
`default_nettype none
module afp_sequencer_tb;
   logic clock = 1'b0, reset = 1'b1;
   logic [1:0] mode_req = 2'b00, mode_level;
   logic fold = 1'b0, tmute = 1'b0, tshut = 1'b0, limit = 1'b0, window = 1'b0;
   logic low_sup = 1'b0, high_sup = 1'b0, imbal = 1'b0;
   logic stage_enable, idle_switching, audio_enable, current_regulate, fault_indicator_n;
   logic [7:0] gain, fall_count, base;
   logic [15:0] low_run;
   int bad_count = 0, checks_done = 0;
   ////////////////////////////////////////////////////////////////////////////////
   always #20 clock = ~clock;
   afp_sequencer #(.CYC_PER_MS(10), .TAU_MS(1)) i_dut (.clock(clock), .reset(reset),
      .mode_level(mode_level), .temp_fold_flag(fold), .temp_mute_flag(tmute),
      .temp_shutdown_flag(tshut), .current_limit_flag(limit), .output_window_flag(window),
      .low_supply_flag(low_sup), .high_supply_flag(high_sup), .rail_imbalance_flag(imbal),
      .stage_enable(stage_enable), .idle_switching(idle_switching),
      .audio_enable(audio_enable), .current_regulate(current_regulate),
      .thermal_gain_rollback(gain), .fault_indicator_n(fault_indicator_n));
   afp_host_model i_host (.clock(clock), .reset(reset), .mode_req(mode_req),
      .mode_level(mode_level), .fault_indicator_n(fault_indicator_n),
      .fall_count(fall_count), .low_run(low_run));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         bad_count++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clock);
   endtask
   function automatic logic sig(input int s);
      case (s)
         0: return stage_enable;
         1: return audio_enable;
         default: return fault_indicator_n;
      endcase
   endfunction
   // bounded wait; a miss ends the run
   task automatic wait_for(input int s, input logic v, input int lim);
      int n;
      n = 0;
      while (sig(s) !== v && n < lim)
      begin
         @(negedge clock);
         n++;
      end
      chk({7'h00, sig(s)}, {7'h00, v});
      if (sig(s) !== v)
         test_done();
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_startup();
      mode_req = 2'b10;
      wait_for(0, 1'b1, 12);
      chk({6'h00, idle_switching, audio_enable}, 8'h02);
      cyc(1400);
      chk({7'h00, audio_enable}, 8'h00);
      wait_for(1, 1'b1, 200);
      chk({6'h00, idle_switching, fault_indicator_n}, 8'h01);
   endtask
   task automatic t_thermal();
      fold = 1'b1;
      cyc(40);
      chk({7'h00, gain < 8'hFF && gain > 8'hF8}, 8'h01);
      tmute = 1'b1;
      cyc(4);
      chk({gain[6:0], audio_enable}, 8'h00);
      fold = 1'b0;
      tmute = 1'b0;
      tshut = 1'b1;
      cyc(4);
      chk({7'h00, stage_enable}, 8'h00);
      tshut = 1'b0;
      wait_for(1, 1'b1, 6);
   endtask
   task automatic t_load_short();
      limit = 1'b1;
      cyc(4);
      chk({5'h00, fault_indicator_n, stage_enable, current_regulate}, 8'h03);
      wait_for(0, 1'b0, 20);
      limit = 1'b0;
      cyc(480);
      chk({7'h00, fault_indicator_n}, 8'h00);
      cyc(40);
      chk({7'h00, fault_indicator_n}, 8'h01);
      cyc(440);
      chk({7'h00, stage_enable}, 8'h00);
      wait_for(0, 1'b1, 60);
      cyc(440);
      chk({7'h00, audio_enable}, 8'h00);
      wait_for(1, 1'b1, 80);
      base = fall_count;
      limit = 1'b1;
      cyc(3600);
      limit = 1'b0;
      chk({7'h00, fall_count - base >= 8'h03}, 8'h01);
      wait_for(1, 1'b1, 2000);
   endtask
   task automatic t_supply_short();
      mode_req = 2'b00;
      wait_for(0, 1'b0, 10);
      window = 1'b1;
      mode_req = 2'b10;
      cyc(200);
      chk({6'h00, stage_enable, fault_indicator_n}, 8'h00);
      chk({7'h00, low_run > 16'd150}, 8'h01);
      window = 1'b0;
      wait_for(0, 1'b1, 10);
      wait_for(1, 1'b1, 1600);
      limit = 1'b1;
      window = 1'b1;
      wait_for(0, 1'b0, 20);
      limit = 1'b0;
      cyc(1200);
      chk({6'h00, stage_enable, fault_indicator_n}, 8'h00);
      window = 1'b0;
      wait_for(0, 1'b1, 12);
      wait_for(1, 1'b1, 1600);
   endtask
   // 0 undervoltage, 1 imbalance, 2 overvoltage
   task automatic t_supply(input int s);
      {high_sup, imbal, low_sup} = 3'b001 << s;
      cyc(4);
      chk({6'h00, stage_enable, fault_indicator_n}, 8'h01);
      {high_sup, imbal, low_sup} = 3'b000;
      if (s < 2)
      begin
         cyc(950);
         chk({7'h00, stage_enable}, 8'h00);
         wait_for(0, 1'b1, 150);
      end
      else
         wait_for(0, 1'b1, 6);
      wait_for(1, 1'b1, 2000);
   endtask
   // mute level, the unused code as standby, then a fresh start
   task automatic t_mute_mode();
      mode_req = 2'b01;
      wait_for(1, 1'b0, 6);
      chk({6'h00, idle_switching, stage_enable}, 8'h03);
      cyc(20);
      chk({7'h00, audio_enable}, 8'h00);
      mode_req = 2'b11;
      wait_for(0, 1'b0, 6);
      mode_req = 2'b10;
      wait_for(0, 1'b1, 12);
      wait_for(1, 1'b1, 2000);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      cyc(2);
      reset = 1'b0;
      chk({5'h00, stage_enable, audio_enable, fault_indicator_n}, 8'h01);
      chk(gain, 8'hFF);
      t_startup();
      t_thermal();
      t_load_short();
      t_supply_short();
      t_supply(0);
      t_supply(1);
      t_supply(2);
      t_mute_mode();
      test_done();
   end
endmodule
`default_nettype wire
